// File: dioe_engine.sv
// Direct I/O request engine: four descriptor sets, flow and credit checks,
// payload fetch, packet build into the shared transmit pool, completion codes.
// Assumes all inputs come from logic on CLK; the pool, flow control and
// response router sit outside, as does the response timer.
`timescale 1ns/10ps
module dioe_engine #(
	parameter int NSETS  = 4,
	parameter int NPORTS = 4,
	parameter int DW     = 32
) (
	// Clock and reset
	input  wire logic                   CLK,
	input  wire logic                   RSTN,
	// Configuration port
	input  wire logic                   CFG_WE,
	input  wire logic [1:0]             CFG_SET,
	input  wire logic [2:0]             CFG_IDX,
	input  wire logic [31:0]            CFG_WDATA,
	output logic [31:0]                 CFG_RDATA,
	// Per-set status and interrupt service
	output logic [NSETS-1:0]            BUSY,
	output logic [3*NSETS-1:0]          CODE,
	output logic [NSETS-1:0]            IRQ_PEND,
	input  wire logic [NSETS-1:0]       IRQ_ACK,
	// Flow control and credit
	output logic [15:0]                 FC_DEST,
	output logic [1:0]                  FC_PRIO,
	input  wire logic                   FC_XOFF,
	input  wire logic [3:0]             CREDIT,
	input  wire logic [NPORTS-1:0]      TXF_SPACE,
	// Payload fetch
	output logic                        DMA_REQ,
	output logic [31:0]                 DMA_ADDR,
	output logic [11:0]                 DMA_BYTES,
	input  wire logic                   DMA_GNT,
	input  wire logic                   DMA_RVALID,
	output logic                        DMA_RREADY,
	input  wire logic [DW-1:0]          DMA_RDATA,
	input  wire logic                   DMA_RLAST,
	input  wire logic                   DMA_RERR,
	// Shared transmit pool
	output logic                        TX_VALID,
	input  wire logic                   TX_READY,
	output logic [DW-1:0]               TX_DATA,
	output logic                        TX_LAST,
	output logic [1:0]                  TX_PORT,
	output logic [1:0]                  TX_PRIO,
	output logic                        TX_COMMIT,
	output logic                        TX_ABORT,
	// Responses and timeouts
	input  wire logic                   RSP_VALID,
	input  wire logic [1:0]             RSP_SET,
	input  wire logic [1:0]             RSP_KIND,
	input  wire logic                   RSP_LEN_ERR,
	input  wire logic [NSETS-1:0]       RSP_TIMEOUT
);
	logic [31:0]       desc_q [NSETS][dioe_pkg::NWORDS];
	logic [NSETS-1:0]  busy_q;
	logic [NSETS-1:0]  pend_q;
	logic [NSETS-1:0]  wait_q;
	logic [NSETS-1:0]  dbell_q;
	logic [NSETS-1:0]  irq_q;
	logic [2:0]        code_q [NSETS];
	logic [NSETS-1:0]  take;
	logic [1:0]        pick;

	dioe_pkg::dioe_state_t st_q;
	logic [1:0]        cur_q;
	logic [1:0]        hw_q;
	logic [2:0]        res_q;
	logic              force_q;
	logic              np_q;
	logic              err_q;
	logic              fin;

	// ****************************************************************
	// Current descriptor decode
	// ****************************************************************
	logic [31:0] rt;
	logic [31:0] ln;
	logic [11:0] bytes;
	logic [3:0]  ftype;
	logic [3:0]  trans;
	logic [1:0]  port;
	logic [1:0]  prio;
	logic        pay;
	logic        posted;
	logic        valid;
	logic        is_dbell;

	assign rt       = desc_q[cur_q][dioe_pkg::W_ROUTING];
	assign ln       = desc_q[cur_q][dioe_pkg::W_LAUNCH];
	assign bytes    = desc_q[cur_q][dioe_pkg::W_BYTES][dioe_pkg::BC_MSB:0];
	assign ftype    = ln[dioe_pkg::LN_FTYPE_LSB +: 4];
	assign trans    = ln[dioe_pkg::LN_TRANS_LSB +: 4];
	assign port     = rt[dioe_pkg::RT_PORT_LSB +: 2];
	assign prio     = rt[dioe_pkg::RT_PRIO_LSB +: 2];
	assign FC_DEST  = rt[dioe_pkg::RT_DEST_LSB +: 16];
	assign FC_PRIO  = prio;
	assign is_dbell = (ftype == dioe_pkg::FT_DBELL);

	// Decode of the supported request types; anything else is refused
	always_comb begin
		pay    = 1'b0;
		posted = 1'b0;
		valid  = 1'b1;
		case (ftype)
			dioe_pkg::FT_NREAD: valid = (trans == dioe_pkg::TR_NREAD);
			dioe_pkg::FT_WRITE: begin
				pay    = 1'b1;
				posted = (trans == dioe_pkg::TR_NWRITE);
				valid  = (trans == dioe_pkg::TR_NWRITE) || (trans == dioe_pkg::TR_NWR_R)
					|| (trans == dioe_pkg::TR_TAS);
			end
			dioe_pkg::FT_SWRITE: begin
				pay    = 1'b1;
				posted = 1'b1;
			end
			dioe_pkg::FT_MAINT: begin
				pay   = (trans == dioe_pkg::TR_MWR);
				valid = ((trans == dioe_pkg::TR_MRD) || (trans == dioe_pkg::TR_MWR))
					&& (bytes <= dioe_pkg::MAINT_BYTES);
			end
			dioe_pkg::FT_DBELL: valid = 1'b1;
			default: valid = 1'b0;
		endcase
		if (rt[dioe_pkg::RT_IDSZ_LSB + 1]) begin
			valid = 1'b0;
		end
		if (32'(port) >= NPORTS) begin
			valid = 1'b0;
		end
		// Segmentation is not supported, so a payload above one packet is refused
		if (!is_dbell && (bytes == 12'h000 || bytes > dioe_pkg::MAX_BYTES)) begin
			valid = 1'b0;
		end
	end

	// ****************************************************************
	// Descriptor sets
	// ****************************************************************
	for (genvar i = 0; i < NSETS; i++) begin : g_set
		logic hit;
		logic launch;
		logic eng_done;
		logic rsp_done;
		logic cmp;
		logic want_irq;
		logic [2:0] ccode;

		assign hit    = CFG_WE && (32'(CFG_SET) == i) && !busy_q[i];
		assign launch = hit && (CFG_IDX == dioe_pkg::W_LAUNCH);
		assign eng_done = fin && (32'(cur_q) == i);
		assign rsp_done = wait_q[i] && (RSP_TIMEOUT[i] || (RSP_VALID && 32'(RSP_SET) == i));
		assign cmp = (eng_done && !np_q) || rsp_done;
		assign want_irq = desc_q[i][dioe_pkg::W_ROUTING][dioe_pkg::RT_IRQ_BIT]
			|| (eng_done && force_q);

		always_comb begin
			if (eng_done) begin
				ccode = res_q;
			end else if (RSP_TIMEOUT[i]) begin
				ccode = dioe_pkg::CC_TIMEOUT;
			end else if (RSP_KIND == dioe_pkg::RK_SEMA) begin
				ccode = dioe_pkg::CC_RETRY;
			end else if (RSP_KIND == dioe_pkg::RK_RETRY && dbell_q[i]) begin
				ccode = dioe_pkg::CC_RETRY;
			end else if (RSP_KIND != dioe_pkg::RK_DONE || RSP_LEN_ERR) begin
				ccode = dioe_pkg::CC_RSP_ERR;
			end else begin
				ccode = dioe_pkg::CC_OK;
			end
		end

		always_ff @(posedge CLK or negedge RSTN) begin
			if (!RSTN) begin
				for (int w = 0; w < dioe_pkg::NWORDS; w++) begin
					desc_q[i][w] <= '0;
				end
			end else if (hit && CFG_IDX < 3'(dioe_pkg::NWORDS)) begin
				desc_q[i][CFG_IDX] <= CFG_WDATA;
			end
		end

		always_ff @(posedge CLK or negedge RSTN) begin
			if (!RSTN) begin
				busy_q[i]  <= 1'b0;
				pend_q[i]  <= 1'b0;
				wait_q[i]  <= 1'b0;
				dbell_q[i] <= 1'b0;
				irq_q[i]   <= 1'b0;
				code_q[i]  <= dioe_pkg::CC_RESET;
			end else begin
				if (launch) begin
					busy_q[i] <= 1'b1;
					pend_q[i] <= 1'b1;
				end
				if (take[i]) begin
					pend_q[i] <= 1'b0;
				end
				if (eng_done && np_q) begin
					wait_q[i]  <= 1'b1;
					dbell_q[i] <= is_dbell;
				end
				if (cmp) begin
					wait_q[i] <= 1'b0;
					code_q[i] <= ccode;
					if (want_irq) begin
						irq_q[i] <= 1'b1;
					end else begin
						busy_q[i] <= 1'b0;
					end
				end
				// Service ends: clear the pending interrupt and release the set
				if (irq_q[i] && IRQ_ACK[i]) begin
					irq_q[i]  <= 1'b0;
					busy_q[i] <= 1'b0;
				end
			end
		end

		assign CODE[3*i +: 3] = code_q[i];
	end

	assign BUSY     = busy_q;
	assign IRQ_PEND = irq_q;

	// Read port: descriptors and the result status word of any set
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			CFG_RDATA <= '0;
		end else if (CFG_IDX == dioe_pkg::W_RESULT) begin
			CFG_RDATA <= {busy_q[CFG_SET], 28'h0000000, code_q[CFG_SET]};
		end else if (CFG_IDX < 3'(dioe_pkg::NWORDS)) begin
			CFG_RDATA <= desc_q[CFG_SET][CFG_IDX];
		end else begin
			CFG_RDATA <= '0;
		end
	end

	// ****************************************************************
	// Round-robin pick of a launched set
	// ****************************************************************
	always_comb begin
		logic [1:0] k;
		logic       got;
		k    = 2'h0;
		got  = 1'b0;
		pick = cur_q;
		for (int n = 1; n <= NSETS; n++) begin
			k = cur_q + 2'(n);
			if (!got && pend_q[k]) begin
				pick = k;
				got  = 1'b1;
			end
		end
		take = '0;
		if (st_q == dioe_pkg::E_IDLE && got) begin
			take[pick] = 1'b1;
		end
	end

	// ****************************************************************
	// Packet build engine
	// ****************************************************************
	logic          bin_valid;
	logic          bin_ready;
	logic [DW:0]   bin_data;
	logic [DW:0]   bout_data;
	logic          bempty;
	logic [DW-1:0] hdr;

	always_comb begin
		case (hw_q)
			2'h0: hdr = DW'(desc_q[cur_q][dioe_pkg::W_ADDR_MSB]);
			2'h1: hdr = DW'(desc_q[cur_q][dioe_pkg::W_ADDR_LSB]);
			2'h2: hdr = DW'(rt);
			default: hdr = DW'(ln);
		endcase
	end

	assign DMA_REQ    = (st_q == dioe_pkg::E_DREQ);
	assign DMA_RREADY = (st_q == dioe_pkg::E_DATA) && bin_ready;
	assign bin_valid  = ((st_q == dioe_pkg::E_DATA) && DMA_RVALID && !DMA_RERR)
		|| (st_q == dioe_pkg::E_HDR);
	// Header follows the payload, so the packet is whole in the pool first
	assign bin_data   = (st_q == dioe_pkg::E_HDR) ? {hw_q == dioe_pkg::HDR_LAST, hdr}
		: {1'b0, DMA_RDATA};
	assign fin        = (st_q == dioe_pkg::E_END);

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			st_q      <= dioe_pkg::E_IDLE;
			cur_q     <= 2'h0;
			hw_q      <= 2'h0;
			res_q     <= dioe_pkg::CC_OK;
			force_q   <= 1'b0;
			np_q      <= 1'b0;
			err_q     <= 1'b0;
			DMA_ADDR  <= '0;
			DMA_BYTES <= '0;
			TX_PORT   <= 2'h0;
			TX_PRIO   <= 2'h0;
			TX_COMMIT <= 1'b0;
			TX_ABORT  <= 1'b0;
		end else begin
			TX_COMMIT <= 1'b0;
			TX_ABORT  <= 1'b0;
			case (st_q)
				dioe_pkg::E_IDLE: begin
					force_q <= 1'b0;
					np_q    <= 1'b0;
					err_q   <= 1'b0;
					hw_q    <= 2'h0;
					if (|take) begin
						cur_q <= pick;
						st_q  <= dioe_pkg::E_CHECK;
					end
				end
				dioe_pkg::E_CHECK: begin
					DMA_ADDR  <= desc_q[cur_q][dioe_pkg::W_DMA_ADDR];
					DMA_BYTES <= bytes;
					TX_PORT   <= port;
					TX_PRIO   <= prio;
					if (!valid) begin
						res_q <= dioe_pkg::CC_INVALID;
						st_q  <= dioe_pkg::E_END;
					end else if (FC_XOFF) begin
						res_q   <= dioe_pkg::CC_XOFF;
						force_q <= 1'b1;
						st_q    <= dioe_pkg::E_END;
					end else if (!CREDIT[prio]) begin
						res_q <= dioe_pkg::CC_CREDIT;
						st_q  <= dioe_pkg::E_END;
					end else begin
						st_q <= dioe_pkg::E_ALLOC;
					end
				end
				dioe_pkg::E_ALLOC: begin
					if (TXF_SPACE[port]) begin
						st_q <= pay ? dioe_pkg::E_DREQ : dioe_pkg::E_HDR;
					end
				end
				dioe_pkg::E_DREQ: begin
					if (DMA_GNT) begin
						st_q <= dioe_pkg::E_DATA;
					end
				end
				dioe_pkg::E_DATA: begin
					if (DMA_RVALID && DMA_RREADY) begin
						if (DMA_RERR) begin
							err_q <= 1'b1;
							st_q  <= dioe_pkg::E_DRAIN;
						end else if (DMA_RLAST) begin
							st_q <= dioe_pkg::E_HDR;
						end
					end
				end
				dioe_pkg::E_HDR: begin
					if (bin_ready) begin
						hw_q <= hw_q + 2'h1;
						if (hw_q == dioe_pkg::HDR_LAST) begin
							st_q <= dioe_pkg::E_DRAIN;
						end
					end
				end
				dioe_pkg::E_DRAIN: begin
					// Forward only after the last word has left the buffer
					if (bempty) begin
						if (err_q) begin
							TX_ABORT <= 1'b1;
							res_q    <= dioe_pkg::CC_DMA_ERR;
						end else begin
							TX_COMMIT <= 1'b1;
							res_q     <= dioe_pkg::CC_OK;
							np_q      <= !posted;
						end
						st_q <= dioe_pkg::E_END;
					end
				end
				dioe_pkg::E_END: begin
					st_q <= dioe_pkg::E_IDLE;
				end
				default: st_q <= dioe_pkg::E_IDLE;
			endcase
		end
	end

	// Words wait here rather than being lost while the pool stalls
	dioe_buf2 #(
		.W(DW + 1)
	) u_buf (
		.CLK       (CLK),
		.RSTN      (RSTN),
		.in_valid  (bin_valid),
		.in_ready  (bin_ready),
		.in_data   (bin_data),
		.out_valid (TX_VALID),
		.out_ready (TX_READY),
		.out_data  (bout_data),
		.empty     (bempty)
	);

	assign TX_DATA = bout_data[DW-1:0];
	assign TX_LAST = bout_data[DW];

endmodule // dioe_engine

// File: dioe_pkg.sv
// Package of the direct I/O engine: descriptor word indices, field layouts,
// completion codes, packet type encodings and engine states.
// Assumes nothing beyond a SystemVerilog compiler.
package dioe_pkg;

	// Descriptor word indices within one set
	localparam logic [2:0] W_ADDR_MSB = 3'h0;
	localparam logic [2:0] W_ADDR_LSB = 3'h1;
	localparam logic [2:0] W_DMA_ADDR = 3'h2;
	localparam logic [2:0] W_BYTES    = 3'h3;
	localparam logic [2:0] W_ROUTING  = 3'h4;
	localparam logic [2:0] W_LAUNCH   = 3'h5;
	localparam logic [2:0] W_RESULT   = 3'h6;
	localparam int         NWORDS     = 6;

	// Routing descriptor word fields
	localparam int RT_DEST_LSB = 0;
	localparam int RT_PRIO_LSB = 16;
	localparam int RT_IDSZ_LSB = 18;
	localparam int RT_PORT_LSB = 20;
	localparam int RT_IRQ_BIT  = 22;
	// Launch descriptor word fields
	localparam int LN_TRANS_LSB = 0;
	localparam int LN_FTYPE_LSB = 4;
	// Byte count field and result word busy bit
	localparam int BC_MSB      = 11;
	localparam int RS_BUSY_BIT = 31;

	// Payload limits without segmentation
	localparam logic [11:0] MAX_BYTES   = 12'h100;
	localparam logic [11:0] MAINT_BYTES = 12'h004;

	// Completion codes
	localparam logic [2:0] CC_OK      = 3'h0;
	localparam logic [2:0] CC_TIMEOUT = 3'h1;
	localparam logic [2:0] CC_XOFF    = 3'h2;
	localparam logic [2:0] CC_RSP_ERR = 3'h3;
	localparam logic [2:0] CC_INVALID = 3'h4;
	localparam logic [2:0] CC_DMA_ERR = 3'h5;
	localparam logic [2:0] CC_RETRY   = 3'h6;
	localparam logic [2:0] CC_CREDIT  = 3'h7;
	localparam logic [2:0] CC_RESET   = 3'h0;

	// Packet type encodings (ftype, trans)
	localparam logic [3:0] FT_NREAD   = 4'h2;
	localparam logic [3:0] FT_WRITE   = 4'h5;
	localparam logic [3:0] FT_SWRITE  = 4'h6;
	localparam logic [3:0] FT_MAINT   = 4'h8;
	localparam logic [3:0] FT_DBELL   = 4'hA;
	localparam logic [3:0] TR_NREAD   = 4'h4;
	localparam logic [3:0] TR_NWRITE  = 4'h4;
	localparam logic [3:0] TR_NWR_R   = 4'h5;
	localparam logic [3:0] TR_TAS     = 4'hE;
	localparam logic [3:0] TR_MRD     = 4'h0;
	localparam logic [3:0] TR_MWR     = 4'h1;

	// Response kinds reported back for a waiting set
	localparam logic [1:0] RK_DONE  = 2'h0;
	localparam logic [1:0] RK_ERROR = 2'h1;
	localparam logic [1:0] RK_RETRY = 2'h2;
	localparam logic [1:0] RK_SEMA  = 2'h3;

	localparam logic [1:0] HDR_LAST = 2'h3;

	typedef enum logic [7:0] {
		E_IDLE  = 8'h01,
		E_CHECK = 8'h02,
		E_ALLOC = 8'h04,
		E_DREQ  = 8'h08,
		E_DATA  = 8'h10,
		E_HDR   = 8'h20,
		E_DRAIN = 8'h40,
		E_END   = 8'h80
	} dioe_state_t;

endpackage

// File: dioe_buf2.sv
// Two-entry buffer with valid/ready on both sides.
// Assumes one clock; the drain side may stall for any time.
`timescale 1ns/10ps
module dioe_buf2 #(
	parameter int W = 33
) (
	// Clock and reset
	input  wire logic         CLK,
	input  wire logic         RSTN,
	// Fill side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// Drain side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data,
	output logic              empty
);
	logic [W-1:0] head_q;
	logic [W-1:0] tail_q;
	logic [1:0]   cnt_q;
	logic         push;
	logic         pop;

	assign in_ready  = (cnt_q != 2'h2);
	assign out_valid = (cnt_q != 2'h0);
	assign empty     = (cnt_q == 2'h0);
	assign out_data  = head_q;
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			cnt_q <= 2'h0;
		end else if (push && !pop) begin
			cnt_q <= cnt_q + 2'h1;
		end else if (pop && !push) begin
			cnt_q <= cnt_q - 2'h1;
		end
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			head_q <= '0;
			tail_q <= '0;
		end else begin
			if (cnt_q == 2'h2 && pop) begin
				head_q <= tail_q;
			end else if (push && (cnt_q == 2'h0 || pop)) begin
				head_q <= in_data;
			end else if (push) begin
				tail_q <= in_data;
			end
		end
	end

endmodule // dioe_buf2

// File: dioe_engine_sva.sv
// Checker of the direct I/O engine ports: busy, codes, fetch and pool handshakes.
// Assumes it is bound to dioe_engine and that sets 0 and 1 are in use.
`timescale 1ns/10ps
module dioe_chk #(
	parameter int NSETS  = 4,
	parameter int NPORTS = 4,
	parameter int DW     = 32
) (
	input  wire logic                CLK,
	input  wire logic                RSTN,
	input  wire logic                CFG_WE,
	input  wire logic [1:0]          CFG_SET,
	input  wire logic [2:0]          CFG_IDX,
	input  wire logic [NSETS-1:0]    BUSY,
	input  wire logic [3*NSETS-1:0]  CODE,
	input  wire logic [NSETS-1:0]    IRQ_PEND,
	input  wire logic [NSETS-1:0]    IRQ_ACK,
	input  wire logic                DMA_REQ,
	input  wire logic                DMA_GNT,
	input  wire logic [31:0]         DMA_ADDR,
	input  wire logic                TX_VALID,
	input  wire logic                TX_READY,
	input  wire logic [DW-1:0]       TX_DATA,
	input  wire logic                TX_LAST,
	input  wire logic                TX_COMMIT,
	input  wire logic                TX_ABORT
);
	// ****************************************
	// Port relations
	// ****************************************
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RSTN);

	a_launch_busy: assert property (CFG_WE && CFG_SET == 2'h0 && CFG_IDX == 3'h5
		&& !BUSY[0] |=> BUSY[0]) else $error("set 0 not busy after launch");
	a_irq_holds: assert property (IRQ_PEND[1] && !IRQ_ACK[1]
		|=> IRQ_PEND[1] && BUSY[1]) else $error("set 1 released before service");
	a_code_frozen: assert property ($changed(CODE[5:3]) |-> $past(BUSY[1]))
		else $error("code of set 1 moved while free");
	a_idle_quiet: assert property (BUSY == '0 |-> !DMA_REQ && !TX_VALID)
		else $error("engine active with no set launched");
	a_req_hold: assert property (DMA_REQ && !DMA_GNT |=> DMA_REQ && $stable(DMA_ADDR))
		else $error("fetch request dropped or changed");
	a_tx_hold: assert property (TX_VALID && !TX_READY
		|=> TX_VALID && $stable(TX_DATA) && $stable(TX_LAST))
		else $error("pool word lost during stall");
	a_commit_drain: assert property (TX_COMMIT |-> !TX_VALID && !TX_ABORT)
		else $error("commit before packet fully written");
	a_commit_pulse: assert property (TX_COMMIT |=> !TX_COMMIT && !TX_ABORT)
		else $error("commit longer than one cycle");
	a_abort_pulse: assert property (TX_ABORT |=> !TX_ABORT && !TX_COMMIT)
		else $error("abort longer than one cycle");

	c_commit: cover property (TX_COMMIT);
	c_abort: cover property (TX_ABORT);
	c_irq: cover property ($rose(IRQ_PEND[0]) or $rose(IRQ_PEND[1]));
endmodule // dioe_chk

bind dioe_engine dioe_chk #(.NSETS(NSETS), .NPORTS(NPORTS), .DW(DW)) dioe_chk_i (
	.CLK(CLK), .RSTN(RSTN), .CFG_WE(CFG_WE), .CFG_SET(CFG_SET), .CFG_IDX(CFG_IDX),
	.BUSY(BUSY), .CODE(CODE), .IRQ_PEND(IRQ_PEND), .IRQ_ACK(IRQ_ACK),
	.DMA_REQ(DMA_REQ), .DMA_GNT(DMA_GNT), .DMA_ADDR(DMA_ADDR),
	.TX_VALID(TX_VALID), .TX_READY(TX_READY), .TX_DATA(TX_DATA), .TX_LAST(TX_LAST),
	.TX_COMMIT(TX_COMMIT), .TX_ABORT(TX_ABORT));

// File: dioe_far.sv
// Far side of the engine: payload memory on the fetch bus and the transmit pool.
// Assumes 32-bit beats; slow mode delays beats and pool acceptance, while grants come every other cycle in both modes.
`timescale 1ns/10ps
module dioe_far (
	// Clock, reset and bench controls
	input  wire logic        CLK,
	input  wire logic        RSTN,
	input  wire logic        slow,
	input  wire logic        bad_beat,
	// Payload fetch
	input  wire logic        DMA_REQ,
	input  wire logic [11:0] DMA_BYTES,
	output logic             DMA_GNT,
	output logic             DMA_RVALID,
	input  wire logic        DMA_RREADY,
	output logic [31:0]      DMA_RDATA,
	output logic             DMA_RLAST,
	output logic             DMA_RERR,
	// Shared transmit pool
	input  wire logic        TX_VALID,
	output logic             TX_READY,
	input  wire logic        TX_COMMIT,
	input  wire logic        TX_ABORT,
	output int               words,
	output int               commits
);
	// ****************************************
	// Behaviour
	// ****************************************
	logic [9:0]  left_q;
	logic [1:0]  ph_q;
	logic [31:0] data_q;

	// Grant only every other cycle so the request must be held
	assign DMA_GNT    = DMA_REQ && ph_q[0];
	assign DMA_RVALID = (left_q != 10'h0) && (!slow || ph_q != 2'h0);
	assign DMA_RLAST  = DMA_RVALID && left_q == 10'h1;
	assign DMA_RERR   = DMA_RVALID && bad_beat;
	// Bus not driven between beats shows the inverse, never a stale match
	assign DMA_RDATA  = DMA_RVALID ? data_q : ~data_q;
	assign TX_READY   = !slow || ph_q != 2'h1;

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			left_q  <= 10'h0;
			ph_q    <= 2'h0;
			data_q  <= 32'hC0DE_0000;
			words   <= 0;
			commits <= 0;
		end else begin
			ph_q <= ph_q + 2'h1;
			if (TX_ABORT)
				left_q <= 10'h0;
			else if (DMA_REQ && DMA_GNT)
				left_q <= 10'((DMA_BYTES + 12'h003) >> 2);
			else if (DMA_RVALID && DMA_RREADY)
				left_q <= left_q - 10'h1;
			if (DMA_RVALID && DMA_RREADY)
				data_q <= data_q + 32'h1;
			if (TX_VALID && TX_READY)
				words <= words + 1;
			if (TX_COMMIT)
				commits <= commits + 1;
		end
	end
endmodule // dioe_far

// File: dioe_engine_test.sv
// Self-checking bench of the direct I/O engine with its far-side model.
// Assumes dioe_pkg, dioe_buf2, dioe_engine, dioe_far and the checker compiled first.
`timescale 1ns/10ps
module dioe_engine_test;
	logic        CLK, RSTN, CFG_WE, FC_XOFF, DMA_REQ, DMA_GNT, DMA_RVALID, DMA_RREADY;
	logic        DMA_RLAST, DMA_RERR, TX_VALID, TX_READY, TX_COMMIT, TX_ABORT;
	logic        RSP_VALID, RSP_LEN_ERR, slow, bad_beat;
	logic [1:0]  CFG_SET, TX_PORT, TX_PRIO, FC_PRIO, RSP_SET, RSP_KIND;
	logic [2:0]  CFG_IDX;
	logic [3:0]  BUSY, IRQ_PEND, IRQ_ACK, CREDIT, TXF_SPACE, RSP_TIMEOUT;
	logic [11:0] CODE, DMA_BYTES;
	logic [15:0] FC_DEST;
	logic [31:0] CFG_WDATA, CFG_RDATA, DMA_RDATA;
	int          failures, comparisons, words, commits;

	dioe_engine dioe_engine_i (.CLK(CLK), .RSTN(RSTN), .CFG_WE(CFG_WE), .CFG_SET(CFG_SET),
		.CFG_IDX(CFG_IDX), .CFG_WDATA(CFG_WDATA), .CFG_RDATA(CFG_RDATA), .BUSY(BUSY),
		.CODE(CODE), .IRQ_PEND(IRQ_PEND), .IRQ_ACK(IRQ_ACK), .FC_DEST(FC_DEST),
		.FC_PRIO(FC_PRIO), .FC_XOFF(FC_XOFF), .CREDIT(CREDIT), .TXF_SPACE(TXF_SPACE),
		.DMA_REQ(DMA_REQ), .DMA_ADDR(), .DMA_BYTES(DMA_BYTES), .DMA_GNT(DMA_GNT),
		.DMA_RVALID(DMA_RVALID), .DMA_RREADY(DMA_RREADY), .DMA_RDATA(DMA_RDATA),
		.DMA_RLAST(DMA_RLAST), .DMA_RERR(DMA_RERR), .TX_VALID(TX_VALID),
		.TX_READY(TX_READY), .TX_DATA(), .TX_LAST(), .TX_PORT(TX_PORT), .TX_PRIO(TX_PRIO),
		.TX_COMMIT(TX_COMMIT), .TX_ABORT(TX_ABORT), .RSP_VALID(RSP_VALID),
		.RSP_SET(RSP_SET), .RSP_KIND(RSP_KIND), .RSP_LEN_ERR(RSP_LEN_ERR),
		.RSP_TIMEOUT(RSP_TIMEOUT));
	dioe_far dioe_far_i (.CLK(CLK), .RSTN(RSTN), .slow(slow), .bad_beat(bad_beat),
		.DMA_REQ(DMA_REQ), .DMA_BYTES(DMA_BYTES), .DMA_GNT(DMA_GNT),
		.DMA_RVALID(DMA_RVALID), .DMA_RREADY(DMA_RREADY), .DMA_RDATA(DMA_RDATA),
		.DMA_RLAST(DMA_RLAST), .DMA_RERR(DMA_RERR), .TX_VALID(TX_VALID),
		.TX_READY(TX_READY), .TX_COMMIT(TX_COMMIT), .TX_ABORT(TX_ABORT),
		.words(words), .commits(commits));

	// ****************************************
	// Flow control and shared tasks
	// ****************************************
	// Only node BEEF at priority 1 is shut down
	assign FC_XOFF = (FC_DEST == 16'hBEEF) && (FC_PRIO == 2'h1);

	initial begin
		CLK = 1'b0;
		forever #10 CLK = ~CLK;
	end

	task automatic give_verdict;
		if (failures == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input int s, input int i, input logic [31:0] d);
		@(posedge CLK);
		CFG_WE    <= 1'b1;
		CFG_SET   <= 2'(s);
		CFG_IDX   <= 3'(i);
		CFG_WDATA <= d;
		@(posedge CLK);
		CFG_WE <= 1'b0;
	endtask

	task automatic rd(input int s, input int i, output logic [31:0] d);
		@(posedge CLK);
		CFG_SET <= 2'(s);
		CFG_IDX <= 3'(i);
		@(posedge CLK);
		#1 d = CFG_RDATA;
	endtask

	task automatic launch(input int s, input logic [31:0] rt, input logic [7:0] ln,
		input logic [11:0] by);
		wr(s, 3, {20'h0, by});
		wr(s, 4, rt);
		wr(s, 5, {24'h0, ln});
		#1 chk(BUSY[s], 1'b1);
	endtask

	task automatic wait_free(input int s);
		for (int n = 0; n < 400; n++) begin
			@(posedge CLK);
			#1;
			if (BUSY[s] === 1'b0)
				break;
		end
		chk(BUSY[s], 1'b0);
	endtask

	task automatic wait_commit(input int t);
		for (int n = 0; n < 600 && commits < t; n++)
			@(posedge CLK);
		repeat (2) @(posedge CLK);
		chk(32'(commits >= t), 32'h1);
	endtask

	task automatic ack(input int s);
		for (int n = 0; n < 400 && IRQ_PEND[s] !== 1'b1; n++)
			@(posedge CLK);
		repeat (3) @(posedge CLK);
		#1 chk(IRQ_PEND[s], 1'b1);
		chk(BUSY[s], 1'b1);
		@(posedge CLK) IRQ_ACK <= 4'(1 << s);
		@(posedge CLK) IRQ_ACK <= 4'h0;
		wait_free(s);
	endtask

	task automatic rsp(input int s, input logic [1:0] k, input logic l, input logic t);
		@(posedge CLK);
		RSP_VALID   <= !t;
		RSP_SET     <= 2'(s);
		RSP_KIND    <= k;
		RSP_LEN_ERR <= l;
		RSP_TIMEOUT <= t ? 4'(1 << s) : 4'h0;
		@(posedge CLK);
		RSP_VALID   <= 1'b0;
		RSP_LEN_ERR <= 1'b0;
		RSP_TIMEOUT <= 4'h0;
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_write;
		int c = commits;
		int w = words;
		logic [31:0] d;
		launch(0, 32'h0010_BEEF, 8'h54, 12'h008);
		wait_free(0);
		chk(words - w, 6);
		chk(commits - c, 1);
		chk(TX_PORT, 2'h1);
		chk(IRQ_PEND[0], 1'b0);
		chk(CODE[2:0], dioe_pkg::CC_OK);
		rd(0, 6, d);
		chk(d, {1'b0, 28'h0, dioe_pkg::CC_OK});
	endtask

	task automatic t_refuse;
		int c;
		for (int i = 0; i < 5; i++) begin
			c = commits;
			@(posedge CLK) CREDIT <= (i == 3) ? 4'hE : 4'hF;
			launch(2, (i == 4) ? 32'h0008_0001 : 32'h0000_0001, (i == 2) ? 8'h34 : 8'h54,
				(i == 0) ? 12'h000 : (i == 1) ? 12'h101 : 12'h008);
			wait_free(2);
			chk(CODE[8:6], (i == 3) ? dioe_pkg::CC_CREDIT : dioe_pkg::CC_INVALID);
			chk(commits - c, 0);
		end
		@(posedge CLK) CREDIT <= 4'hF;
	endtask

	task automatic t_xoff;
		int c = commits;
		launch(1, 32'h0001_BEEF, 8'h54, 12'h008);
		ack(1);
		chk(commits - c, 0);
		chk(CODE[5:3], dioe_pkg::CC_XOFF);
		chk(TX_PRIO, 2'h1);
	endtask

	task automatic t_dmaerr;
		int c = commits;
		@(posedge CLK) bad_beat <= 1'b1;
		launch(3, 32'h0000_0001, 8'h54, 12'h008);
		wait_free(3);
		chk(CODE[11:9], dioe_pkg::CC_DMA_ERR);
		chk(commits - c, 0);
		@(posedge CLK) bad_beat <= 1'b0;
	endtask

	task automatic t_four;
		int c = commits;
		int w = words;
		logic [31:0] d;
		logic [1:0] kind [4] = '{2'h0, 2'h1, 2'h3, 2'h0};
		logic [2:0] want [4] = '{3'h0, 3'h3, 3'h6, 3'h1};
		logic [7:0] lnv [4] = '{8'h24, 8'h55, 8'h5E, 8'h24};
		@(posedge CLK) slow <= 1'b0;
		for (int s = 0; s < 4; s++)
			launch(s, {10'h0, 2'(s), 4'h0, 16'hBEEF}, lnv[s], 12'h008);
		wait_commit(c + 4);
		#1 chk(BUSY, 4'hF);
		chk(words - w, 20);
		wr(0, 0, 32'h0000_00A5);
		rd(0, 0, d);
		chk(d, 32'h0);
		for (int s = 0; s < 4; s++) begin
			rsp(s, kind[s], 1'b0, s == 3);
			wait_free(s);
			chk(CODE[3*s +: 3], want[s]);
		end
	endtask

	task automatic t_bell;
		launch(1, 32'h0000_0001, 8'hA0, 12'h000);
		wait_commit(commits + 1);
		rsp(1, 2'h2, 1'b0, 1'b0);
		wait_free(1);
		chk(CODE[5:3], dioe_pkg::CC_RETRY);
		launch(1, 32'h0040_0001, 8'h24, 12'h008);
		wait_commit(commits + 1);
		rsp(1, 2'h0, 1'b1, 1'b0);
		ack(1);
		chk(CODE[5:3], dioe_pkg::CC_RSP_ERR);
	endtask

	initial begin
		failures    = 0;
		comparisons = 0;
		RSTN        = 1'b0;
		CFG_WE      = 1'b0;
		CFG_SET     = 2'h0;
		CFG_IDX     = 3'h0;
		CFG_WDATA   = 32'h0;
		IRQ_ACK     = 4'h0;
		CREDIT      = 4'hF;
		TXF_SPACE   = 4'hF;
		RSP_VALID   = 1'b0;
		RSP_SET     = 2'h0;
		RSP_KIND    = 2'h0;
		RSP_LEN_ERR = 1'b0;
		RSP_TIMEOUT = 4'h0;
		slow        = 1'b1;
		bad_beat    = 1'b0;
		repeat (2) @(posedge CLK);
		RSTN <= 1'b1;
		#1 chk(BUSY, 4'h0);
		chk(CODE, 12'h000);
		t_write;
		t_refuse;
		t_xoff;
		t_dmaerr;
		t_four;
		t_bell;
		give_verdict;
	end

	// Whole run needs well under 20000 cycles
	initial begin
		#400000;
		failures++;
		give_verdict;
	end
endmodule // dioe_engine_test
